// *** hdl/aebc_bus_ctrl.sv ***
`timescale 1ns/10ps
// Operation
// - bus has 24-bit address and 16-bit data path
// - each access sized dynamically for 8-bit or 16-bit ports
// - byte, word and long-word operands supported
// - 8-bit port splits operand into successive cycles
// - device acknowledge sets cycle length; cycle open until acknowledge
// - every cycle uses asynchronous handshake
// - address strobe marks address; data strobe times data
// - address, size, space and direction driven together at start
// - size shows bytes remaining, valid while address strobe asserted
// - size code: 01 byte, 10 word, 11 three, 00 long
// - direction changes only at cycle start on read/write change
// - three-bit space code selects one of eight spaces
// - space code 7 is cpu space for control cycles
// - space code held valid while address strobe asserted
// - chip-select logic synchronised with transfers, may make controls
// - interrupt acknowledge cycle drives space code all ones
module aebc_bus_ctrl (
	input  wire logic                      i_mclk,
	input  wire logic                      i_resetn,
	input  wire logic                      i_req_valid,
	output logic                           o_req_ready,
	input  wire aebc_pkg::aebc_req_s       i_req,
	output logic                           o_done,
	output logic [31:0]                    o_rdata,
	output logic [aebc_pkg::ADDR_W-1:0]    o_addr,
	output logic [aebc_pkg::DATA_W-1:0]    o_data_out,
	output logic [aebc_pkg::DATA_W-1:0]    o_data_oe_n,
	input  wire logic [aebc_pkg::DATA_W-1:0] i_data_in,
	output aebc_pkg::aebc_ctl_s            o_ctl,
	input  wire logic                      i_port_width_ack_hi_n,
	input  wire logic                      i_port_width_ack_lo_n,
	output logic                           o_cs_cycle
);
	import aebc_pkg::*;

	// ----------------------------------------
	// cycle state
	// ----------------------------------------
	aebc_state_e       state_ff, nxt_state;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [31:0]       buf_ff, nxt_buf;
	logic [2:0]        bytes_ff, nxt_bytes;
	logic              rw_ff, nxt_rw;
	logic [2:0]        space_ff, nxt_space;
	logic              as_n_ff, nxt_as_n;
	logic              ds_n_ff, nxt_ds_n;
	logic              done_ff, nxt_done;
	logic [31:0]       rdata_ff, nxt_rdata;
	logic [DATA_W-1:0] dout_ff, nxt_dout;
	logic              doe_n_ff, nxt_doe_n;
	logic [1:0]        size_w;
	logic [1:0]        ack;
	logic              acked;
	logic              port8;

	assign ack   = {i_port_width_ack_hi_n, i_port_width_ack_lo_n};
	assign acked = (ack != ACK_NONE);
	assign port8 = (ack == ACK_PORT8);

	aebc_sizer u_sizer (
		.i_bytes (bytes_ff),
		.o_size  (size_w)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_addr  = addr_ff;
		nxt_buf   = buf_ff;
		nxt_bytes = bytes_ff;
		nxt_rw    = rw_ff;
		nxt_space = space_ff;
		nxt_as_n  = as_n_ff;
		nxt_ds_n  = ds_n_ff;
		nxt_done  = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_dout  = dout_ff;
		nxt_doe_n = doe_n_ff;
		case (state_ff)
			ST_IDLE: begin
				if (i_req_valid) begin
					nxt_addr  = i_req.addr;
					// direction follows request only at start
					nxt_rw    = i_req.read;
					// acknowledge cycles forced to cpu space
					nxt_space = i_req.iack ? SPACE_CPU : i_req.space;
					// operand byte count from requested size
					case (i_req.size)
						SIZE_BYTE: nxt_bytes = 3'h1;
						SIZE_WORD: nxt_bytes = 3'h2;
						default:   nxt_bytes = BYTES_LONG;
					endcase
					// left-justify so the next bytes sit on top
					case (i_req.size)
						SIZE_BYTE: nxt_buf = {i_req.wdata[7:0], 24'h000000};
						SIZE_WORD: nxt_buf = {i_req.wdata[15:0], 16'h0000};
						default:   nxt_buf = i_req.wdata;
					endcase
					nxt_rdata = 32'h00000000;
					nxt_state = ST_ADDR;
				end
			end
			ST_ADDR: begin
				nxt_as_n  = 1'b0;
				nxt_ds_n  = 1'b0;
				nxt_doe_n = rw_ff;
				nxt_dout  = buf_ff[31:16];
				nxt_state = ST_DATA;
			end
			ST_DATA: begin
				if (acked) begin
					nxt_as_n  = 1'b1;
					nxt_ds_n  = 1'b1;
					nxt_doe_n = 1'b1;
					// 8-bit port or last single byte: upper lane, next address
					if (port8 || bytes_ff == 3'h1) begin
						nxt_rdata = {rdata_ff[23:0], i_data_in[15:8]};
						nxt_buf   = {buf_ff[23:0], 8'h00};
						nxt_bytes = bytes_ff - 3'h1;
						nxt_addr  = addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
					end else begin
						nxt_rdata = {rdata_ff[15:0], i_data_in};
						nxt_buf   = {buf_ff[15:0], 16'h0000};
						nxt_bytes = bytes_ff - 3'h2;
						nxt_addr  = addr_ff + {{(ADDR_W-2){1'b0}}, 2'h2};
					end
					nxt_state = ST_RECOV;
				end
			end
			ST_RECOV: begin
				if (!acked) begin
					if (bytes_ff == 3'h0) begin
						nxt_done  = 1'b1;
						nxt_state = ST_IDLE;
					end else begin
						nxt_state = ST_ADDR;
					end
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= ST_IDLE;
			addr_ff  <= '0;
			buf_ff   <= 32'h00000000;
			bytes_ff <= RST_BYTES;
			rw_ff    <= RST_RW;
			space_ff <= 3'h0;
			as_n_ff  <= 1'b1;
			ds_n_ff  <= 1'b1;
			done_ff  <= 1'b0;
			rdata_ff <= 32'h00000000;
			dout_ff  <= 16'h0000;
			doe_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			addr_ff  <= nxt_addr;
			buf_ff   <= nxt_buf;
			bytes_ff <= nxt_bytes;
			rw_ff    <= nxt_rw;
			space_ff <= nxt_space;
			as_n_ff  <= nxt_as_n;
			ds_n_ff  <= nxt_ds_n;
			done_ff  <= nxt_done;
			rdata_ff <= nxt_rdata;
			dout_ff  <= nxt_dout;
			doe_n_ff <= nxt_doe_n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// 24-bit address, 16-bit data
	assign o_addr      = addr_ff;
	assign o_data_out  = dout_ff;
	assign o_data_oe_n = {DATA_W{doe_n_ff}};
	assign o_req_ready = (state_ff == ST_IDLE);
	assign o_done      = done_ff;
	assign o_rdata     = rdata_ff;
	// held stable by state while strobe low
	assign o_ctl = '{
		size:                size_w,
		space:               space_ff,
		rw:                  rw_ff,
		addr_valid_strobe_n: as_n_ff,
		data_strobe_n:       ds_n_ff
	};
	assign o_cs_cycle  = !as_n_ff && (space_ff != SPACE_CPU);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_size_stable: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!as_n_ff && !$rose(as_n_ff) && !$past(as_n_ff) |-> $stable(o_ctl.size))
		else $error("size changed under address strobe");
	a_space_stable: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!$past(as_n_ff) && !as_n_ff |-> $stable(space_ff))
		else $error("space changed under address strobe");
	a_rw_stable: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff != ST_IDLE && $past(state_ff) != ST_IDLE |-> $stable(rw_ff))
		else $error("direction changed mid transfer");
	a_open_wait: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff == ST_DATA && !acked |=> !as_n_ff)
		else $error("cycle closed without acknowledge");
	a_strobe_neg: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff == ST_DATA && acked |=> as_n_ff && ds_n_ff)
		else $error("strobes not negated after acknowledge");
	a_iack_space: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff == ST_IDLE && i_req_valid && i_req.iack |=> space_ff == SPACE_CPU)
		else $error("acknowledge cycle not cpu space");
	a_byte_step: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff == ST_DATA && port8 |=> addr_ff == $past(addr_ff) + 24'h000001)
		else $error("8-bit step not plus one");
	a_strobe_pair: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		$fell(as_n_ff) |-> !ds_n_ff ##1 (state_ff == ST_DATA || state_ff == ST_RECOV))
		else $error("data strobe missing");

	// ----------------------------------------
	// handshake, lane and qualifier checks
	// ----------------------------------------
	a_launch_set: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		$fell(as_n_ff)
		|-> $stable(addr_ff) && $stable(space_ff) && $stable(rw_ff) && $stable(bytes_ff))
		else $error("qualifiers moved with address strobe");

	a_size_code: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!as_n_ff |-> o_ctl.size == ((bytes_ff == 3'h1) ? SIZE_BYTE :
			(bytes_ff == 3'h2) ? SIZE_WORD : (bytes_ff == 3'h3) ? SIZE_THREE : SIZE_LONG))
		else $error("size code does not match bytes left");

	a_byte_lane: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!ds_n_ff && !rw_ff && bytes_ff == 3'h1
		|-> o_data_out[7:0] == 8'h00)
		else $error("last byte not on upper lane");

	a_oe_write: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!ds_n_ff
		|-> o_data_oe_n == {DATA_W{rw_ff}})
		else $error("data drive does not follow direction");

	a_oe_release: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		ds_n_ff
		|-> &o_data_oe_n)
		else $error("data driven outside data strobe");

	a_ready_strobe: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!as_n_ff
		|-> !o_req_ready)
		else $error("ready while a bus cycle is open");

	a_done_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_done
		|=> !o_done)
		else $error("done longer than one cycle");

	a_done_quiet: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_done
		|-> as_n_ff && ds_n_ff && o_req_ready)
		else $error("done with strobes still asserted");

	a_word_step: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff == ST_DATA && acked && !port8 && bytes_ff != 3'h1
		|=> addr_ff == $past(addr_ff) + 24'h000002)
		else $error("16-bit step not plus two");

	a_byte_count: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff == ST_DATA && port8
		|=> bytes_ff == $past(bytes_ff) - 3'h1)
		else $error("byte count not reduced by one");

	a_recov_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		state_ff == ST_RECOV && acked
		|=> state_ff == ST_RECOV && as_n_ff)
		else $error("next cycle before acknowledge release");

	a_cpu_no_cs: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		space_ff == SPACE_CPU
		|-> !o_cs_cycle)
		else $error("chip-select qualifier in cpu space");

	a_cs_strobe: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!as_n_ff && space_ff != SPACE_CPU
		|-> o_cs_cycle)
		else $error("chip-select qualifier missing");

	a_state_onehot: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		1'b1
		|-> $onehot(state_ff))
		else $error("cycle state not one-hot");
endmodule

// *** hdl/aebc_pkg.sv ***
package aebc_pkg;
	// ----------------------------------------
	// bus widths
	// ----------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;

	// ----------------------------------------
	// transfer-size encodings {hi,lo}
	// ----------------------------------------
	localparam logic [1:0] SIZE_BYTE  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam logic [1:0] SIZE_THREE = 2'h3;
	localparam logic [1:0] SIZE_LONG  = 2'h0;

	// ----------------------------------------
	// address-space codes
	// ----------------------------------------
	localparam logic [2:0] SPACE_CPU = 3'h7;

	// ----------------------------------------
	// acknowledge pair {hi,lo}, active low
	// ----------------------------------------
	localparam logic [1:0] ACK_NONE  = 2'h3;
	localparam logic [1:0] ACK_PORT8 = 2'h2;

	// ----------------------------------------
	// reset values and counts
	// ----------------------------------------
	localparam logic [2:0] RST_BYTES = 3'h0;
	localparam logic       RST_RW    = 1'b1;
	localparam logic [2:0] BYTES_LONG = 3'h4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic [1:0]        size;
		logic              read;
		logic [2:0]        space;
		logic              iack;
	} aebc_req_s;

	typedef struct packed {
		logic [1:0] size;
		logic [2:0] space;
		logic       rw;
		logic       addr_valid_strobe_n;
		logic       data_strobe_n;
	} aebc_ctl_s;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_ADDR   = 4'h2,
		ST_DATA   = 4'h4,
		ST_RECOV  = 4'h8
	} aebc_state_e;
endpackage

// *** hdl/aebc_sizer.sv ***
`timescale 1ns/10ps
module aebc_sizer (
	input  wire logic [2:0] i_bytes,
	output logic      [1:0] o_size
);
	import aebc_pkg::*;
	always_comb begin
		case (i_bytes)
			3'h1:    o_size = SIZE_BYTE;
			3'h2:    o_size = SIZE_WORD;
			3'h3:    o_size = SIZE_THREE;
			default: o_size = SIZE_LONG;
		endcase
	end
endmodule

// *** dv/aebc_ext_dev.sv ***
`timescale 1ns/10ps
module aebc_ext_dev (
	input  wire logic                  i_mclk,
	input  wire logic                  i_port8,
	input  wire logic [3:0]            i_wait,
	input  wire aebc_pkg::aebc_ctl_s   i_ctl,
	input  wire logic [23:0]           i_addr,
	output logic                       o_ack_hi_n,
	output logic                       o_ack_lo_n,
	output logic [15:0]                o_data
);
	import aebc_pkg::*;
	logic [3:0]  cnt;
	logic [15:0] last;
	initial begin
		cnt = 4'h0;
		last = 16'h0;
		o_data = 16'hFFFF;
		{o_ack_hi_n, o_ack_lo_n} = ACK_NONE;
	end
	always @(posedge i_mclk) begin
		if (i_ctl.addr_valid_strobe_n) begin
			cnt <= 4'h0;
			{o_ack_hi_n, o_ack_lo_n} <= ACK_NONE;
			// released lines: never show last value
			o_data <= ~last;
		end else if (cnt == i_wait) begin
			{o_ack_hi_n, o_ack_lo_n} <= i_port8 ? ACK_PORT8 : 2'h0;
			o_data <= {i_addr[7:0], i_port8 ? 8'hA5 : ~i_addr[7:0]};
			last <= {i_addr[7:0], i_port8 ? 8'hA5 : ~i_addr[7:0]};
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// *** dv/test_aebc_bus_ctrl.sv ***
`timescale 1ns/10ps
module test_aebc_bus_ctrl;
	import aebc_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        req_valid = 1'b0;
	aebc_req_s   req = '0;
	logic        port8 = 1'b0;
	logic [3:0]  wait_n = 4'h0;
	logic        ready, done, cs, ack_hi_n, ack_lo_n, as_prev = 1'b1;
	logic [31:0] rdata, got;
	logic [23:0] addr;
	logic [15:0] dout, oe_n, din;
	aebc_ctl_s   ctl;
	aebc_ctl_s   c_ctl [8];
	logic [23:0] c_addr [8];
	logic [15:0] c_dout [8];
	logic        c_cs [8];
	logic [15:0] c_oe [8];
	int          n_cyc, n_fail = 0, samples_checked = 0;

	aebc_bus_ctrl i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_req_valid(req_valid),
		.o_req_ready(ready), .i_req(req), .o_done(done), .o_rdata(rdata), .o_addr(addr),
		.o_data_out(dout), .o_data_oe_n(oe_n), .i_data_in(din), .o_ctl(ctl),
		.i_port_width_ack_hi_n(ack_hi_n), .i_port_width_ack_lo_n(ack_lo_n), .o_cs_cycle(cs));
	aebc_ext_dev i_dev (.i_mclk(i_mclk), .i_port8(port8), .i_wait(wait_n), .i_ctl(ctl),
		.i_addr(addr), .o_ack_hi_n(ack_hi_n), .o_ack_lo_n(ack_lo_n), .o_data(din));

	always #5 i_mclk = ~i_mclk;
	// ----------------------------------------
	// log each bus cycle at address strobe fall
	// ----------------------------------------
	always @(negedge i_mclk) begin
		if (!ctl.addr_valid_strobe_n && as_prev && n_cyc < 8) begin
			c_ctl[n_cyc] = ctl;
			c_oe[n_cyc] = oe_n;
			c_addr[n_cyc] = addr;
			c_dout[n_cyc] = dout;
			c_cs[n_cyc] = cs;
			n_cyc++;
		end
		as_prev <= ctl.addr_valid_strobe_n;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic xfer(input logic [23:0] a, input logic [31:0] wd, input logic [1:0] sz,
		input logic rd, input logic [2:0] sp, input logic ia);
		int n;
		n = 0;
		n_cyc = 0;
		@(negedge i_mclk);
		while (ready !== 1'b1 && n < 50) begin
			@(negedge i_mclk);
			n++;
		end
		check("ready", 1'b1, ready);
		req = '{addr: a, wdata: wd, size: sz, read: rd, space: sp, iack: ia};
		req_valid = 1'b1;
		@(negedge i_mclk);
		req_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(negedge i_mclk);
			n++;
		end
		got = rdata;
		check("done", 1'b1, done);
	endtask

	task automatic t_reset_state();
		check("ready", 1'b1, ready);
		check("strobe", 1'b1, ctl.addr_valid_strobe_n);
		check("oe_n", 16'hFFFF, oe_n);
		check("done", 1'b0, done);
		check("cs", 1'b0, cs);
	endtask

	task automatic t_long_write16();
		port8 = 1'b0;
		wait_n = 4'h1;
		xfer(24'h000100, 32'hDEADBEEF, SIZE_LONG, 1'b0, 3'h6, 1'b0);
		check("cycles", 2, n_cyc);
		check("size", SIZE_LONG, c_ctl[0].size);
		check("size", SIZE_WORD, c_ctl[1].size);
		check("addr", 24'h000102, c_addr[1]);
		check("data", 16'hDEAD, c_dout[0]);
		check("data", 16'hBEEF, c_dout[1]);
		check("rw", 1'b0, c_ctl[0].rw);
		check("space", 3'h6, c_ctl[1].space);
		check("oe_n", 16'h0000, c_oe[1]);
	endtask

	task automatic t_word_read16();
		port8 = 1'b0;
		wait_n = 4'h2;
		xfer(24'h123456, 32'h0, SIZE_WORD, 1'b1, 3'h5, 1'b0);
		check("rdata", 32'h000056A9, got);
		check("cycles", 1, n_cyc);
		check("size", SIZE_WORD, c_ctl[0].size);
		check("rw", 1'b1, c_ctl[0].rw);
		check("space", 3'h5, c_ctl[0].space);
		check("cs", 1'b1, c_cs[0]);
		check("ds", 1'b0, c_ctl[0].data_strobe_n);
		check("oe_n", 16'hFFFF, c_oe[0]);
	endtask

	task automatic t_long_write8();
		logic [1:0] sz [4];
		sz = '{SIZE_LONG, SIZE_THREE, SIZE_WORD, SIZE_BYTE};
		port8 = 1'b1;
		wait_n = 4'h0;
		xfer(24'h0000F0, 32'hDEADBEEF, SIZE_LONG, 1'b0, 3'h1, 1'b0);
		check("cycles", 4, n_cyc);
		for (int i = 0; i < 4; i++) begin
			check("size", sz[i], c_ctl[i].size);
			check("addr", 24'h0000F0 + i, c_addr[i]);
			check("lane", 32'hDEADBEEF >> (24 - 8 * i) & 32'hFF, c_dout[i][15:8]);
			check("rw", 1'b0, c_ctl[i].rw);
			check("oe_n", 16'h0000, c_oe[i]);
		end
	endtask

	task automatic t_long_read8();
		port8 = 1'b1;
		wait_n = 4'h3;
		xfer(24'h000010, 32'h0, SIZE_LONG, 1'b1, 3'h2, 1'b0);
		check("rdata", 32'h10111213, got);
		check("cycles", 4, n_cyc);
		check("rw", 1'b1, c_ctl[0].rw);
	endtask

	task automatic t_iack();
		port8 = 1'b0;
		wait_n = 4'h1;
		xfer(24'hFFFFF5, 32'h0, SIZE_BYTE, 1'b1, 3'h2, 1'b1);
		check("space", SPACE_CPU, c_ctl[0].space);
		check("cs", 1'b0, c_cs[0]);
		check("rdata", 32'h000000F5, got);
	endtask

	task automatic give_verdict();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge i_mclk);
		i_resetn = 1'b1;
		t_reset_state();
		t_word_read16();
		t_long_write8();
		t_long_read8();
		t_iack();
		t_long_write16();
		give_verdict();
	end

	// sequence needs well under a thousand cycles
	initial begin
		#50000;
		n_fail++;
		give_verdict();
	end
endmodule
